// ---- core/ahp_pkg.sv ----
// Purpose: shared constants and types for the converter host port
// Assumes: one clock, sys_clk at 250 MHz
// Notes: cycle counts are in sequencer steps of one sys_clk each
package ahp_pkg;
    localparam int unsigned RES_W = 12;
    localparam int unsigned BUS_W = 8;
    localparam logic [7:0] CONV_CYCLES = 8'd17;
    localparam logic [7:0] CAL_CYCLES = 8'd168;
    localparam logic [7:0] PRE_CYCLES = 8'd5;
    localparam logic [7:0] MSB_READY_CYCLE = 8'd9;
    localparam int unsigned AUX_HOLD_BIT = 0;
    localparam int unsigned AUX_CALREQ_BIT = 1;
    localparam int unsigned AUX_PIN26_BIT = 2;
    localparam int unsigned STATUS_BIT = 7;
    localparam logic [1:0] AUX_RESET = 2'h0;
    localparam logic [RES_W-1:0] RESULT_RESET = 12'h000;

    typedef enum logic [1:0] {
        AHP_IDLE = 2'b00,
        AHP_CAL = 2'b01,
        AHP_CONV = 2'b11
    } ahp_state_t;

    // host strobes and address lines
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic upper_byte_sel;
        logic aux_reg_select;
        logic chan_sel_1;
        logic chan_sel_0;
    } ahp_host_t;

    // output and enable half of the three-signal data bus
    typedef struct packed {
        logic [BUS_W-1:0] dout;
        logic [BUS_W-1:0] doe;
    } ahp_bus_out_t;
endpackage : ahp_pkg

// ---- core/ahp_port.sv ----
// Purpose: host port and conversion sequencing of a 4-channel 12-bit converter
// Assumes: host pins synchronous to sys_clk; comparator decision is an input
// Notes: power-down, power fail and cal error are not modelled
`timescale 1ns/1ps
module ahp_port
    import ahp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire ahp_host_t host,
    input wire logic trim_request_n,
    input wire logic [BUS_W-1:0] bus_in,
    input wire logic cmp_decision,
    output ahp_bus_out_t bus,
    output logic busy_n,
    output logic [1:0] analog_channel,
    output logic sample_hold,
    output logic calibrating
);
    ahp_state_t state;
    ahp_state_t next_state;
    logic [7:0] count;
    logic [7:0] next_count;
    logic [1:0] chan;
    logic output_hold_mode_bit;
    logic pin26_function_bit;
    logic cal_cmd;
    logic cal_at_reset;
    logic wr_d;
    logic trig_d;
    logic [RES_W-1:0] sar;
    logic [RES_W-1:0] out_reg;

    // internal strobes from select and read/write
    wire rd_int = ~host.cs_n & ~host.rd_n;
    wire wr_int = ~host.cs_n & ~host.wr_n;
    wire wr_end = wr_d & ~wr_int;
    wire aux_wr = wr_end & host.aux_reg_select & host.upper_byte_sel;
    wire aux_cal = aux_wr & bus_in[AUX_CALREQ_BIT];
    wire trig_rise = pin26_function_bit & trim_request_n & ~trig_d;
    // a written command calibrates at once in idle, once idle again after a conversion; one written in calibration is cleared by it unless in its last cycle
    wire cal_req = (~pin26_function_bit & ~trim_request_n) | cal_cmd | cal_at_reset |
                   aux_cal;
    wire conv_req = wr_end | trig_rise;
    wire in_sar = (state == AHP_CONV) && (count >= PRE_CYCLES);
    wire [3:0] bit_idx = 4'(RES_W - 1 - 32'(count - PRE_CYCLES));
    wire conv_done = (state == AHP_CONV) && (count == CONV_CYCLES - 8'd1);

    // decision applied to the trial bit of the approximation register
    function automatic logic [RES_W-1:0] sar_step(input logic [RES_W-1:0] v,
                                                  input logic [3:0] idx,
                                                  input logic d);
        logic [RES_W-1:0] r;
        r = v;
        r[idx] = d;
        return r;
    endfunction : sar_step

    // sequencer transitions
    always_comb begin
        next_state = state;
        next_count = count + 8'd1;
        case (state)
            AHP_IDLE: begin
                next_count = 8'h00;
                if (cal_req) begin
                    next_state = AHP_CAL;
                end else if (conv_req) begin
                    next_state = AHP_CONV;
                end
            end
            AHP_CAL: begin
                if (count == CAL_CYCLES - 8'd1) begin
                    next_state = AHP_CONV;
                    next_count = 8'h00;
                end
            end
            AHP_CONV: begin
                if (conv_done) begin
                    next_state = AHP_IDLE;
                    next_count = 8'h00;
                end
            end
            default: begin
                next_state = AHP_IDLE;
                next_count = 8'h00;
            end
        endcase
    end

    // state, counter and edge history
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= AHP_IDLE;
            count <= 8'h00;
            wr_d <= 1'b0;
            trig_d <= 1'b1;
        end else begin
            state <= next_state;
            count <= next_count;
            wr_d <= wr_int;
            trig_d <= trim_request_n;
        end
    end

    // channel capture at the end of the write pulse
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            chan <= 2'h0;
        end else if (wr_end) begin
            chan <= {host.chan_sel_1, host.chan_sel_0};
        end
    end

    // aux mode bits and calibration command
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            output_hold_mode_bit <= AUX_RESET[0];
            pin26_function_bit <= AUX_RESET[1];
            cal_cmd <= 1'b0;
            cal_at_reset <= 1'b1;
        end else begin
            if (aux_wr) begin
                output_hold_mode_bit <= bus_in[AUX_HOLD_BIT];
                pin26_function_bit <= bus_in[AUX_PIN26_BIT];
            end
            // command stays pending until calibration runs; a new command wins
            if (aux_cal) begin
                cal_cmd <= 1'b1;
            end else if (state == AHP_CAL) begin
                cal_cmd <= 1'b0;
            end
            if (state == AHP_CAL) begin
                cal_at_reset <= 1'b0;
            end
        end
    end

    // approximation register and output register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sar <= RESULT_RESET;
            out_reg <= RESULT_RESET;
        end else begin
            if (state == AHP_IDLE && conv_req) begin
                sar <= RESULT_RESET;
            end else if (in_sar) begin
                sar <= sar_step(sar, bit_idx, cmp_decision);
            end
            if (!output_hold_mode_bit && in_sar) begin
                out_reg <= sar_step(sar, bit_idx, cmp_decision);
            end else if (output_hold_mode_bit && conv_done) begin
                out_reg <= sar_step(sar, bit_idx, cmp_decision);
            end
        end
    end

    // read data selection
    wire [7:0] low_byte = out_reg[7:0];
    wire [7:0] high_byte = {~busy_n, 3'h0, out_reg[11:8]};
    wire [7:0] aux_byte = {~busy_n, 4'h0, pin26_function_bit, calibrating,
                           output_hold_mode_bit};
    wire [7:0] rd_byte = !host.upper_byte_sel ? low_byte :
                         host.aux_reg_select ? aux_byte : high_byte;

    // outputs
    assign bus.dout = rd_byte;
    assign bus.doe = {BUS_W{rd_int}};
    assign busy_n = (state == AHP_IDLE);
    assign analog_channel = chan;
    assign sample_hold = (state == AHP_CONV) && (count >= PRE_CYCLES);
    assign calibrating = (state == AHP_CAL);

    // a finished write launches a conversion one cycle later
    sequence write_end_s;
        wr_d && !wr_int && state == AHP_IDLE && !cal_req;
    endsequence
    property launch_p;
        @(posedge sys_clk) disable iff (rst) write_end_s |=> !busy_n;
    endproperty
    launch_busy_a: assert property (launch_p)
        else $error("busy not low after write end");

    conv_length_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(state == AHP_CONV) && $past(state) == AHP_IDLE |-> ##16 busy_n == 1'b0 ##1 busy_n)
        else $error("conversion length wrong");
    cal_length_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(calibrating) |-> ##167 calibrating ##1 (state == AHP_CONV))
        else $error("calibration length wrong");
    bus_release_a: assert property (@(posedge sys_clk) disable iff (rst)
        (host.cs_n || host.rd_n) |-> bus.doe == 8'h00)
        else $error("bus driven outside read");
    status_bit_a: assert property (@(posedge sys_clk) disable iff (rst)
        rd_int && host.upper_byte_sel && !host.aux_reg_select |->
        bus.dout[STATUS_BIT] == !busy_n && bus.dout[6:4] == 3'h0)
        else $error("high byte status wrong");
    hold_keep_a: assert property (@(posedge sys_clk) disable iff (rst)
        output_hold_mode_bit && $past(output_hold_mode_bit) && !$past(conv_done) |->
        $stable(out_reg))
        else $error("latched result changed");
    chan_latch_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_end |=> chan == $past({host.chan_sel_1, host.chan_sel_0}))
        else $error("channel not captured");
    low_byte_a: assert property (@(posedge sys_clk) disable iff (rst)
        rd_int && !host.upper_byte_sel |-> bus.dout == out_reg[7:0])
        else $error("low byte wrong");
    trim_cal_a: assert property (@(posedge sys_clk) disable iff (rst)
        state == AHP_IDLE && !pin26_function_bit && !trim_request_n |=> calibrating)
        else $error("calibration not started");

    // reset leaves transparent mode and queues a calibration
    mode_reset_a: assert property (@(posedge sys_clk)
        $fell(rst) |-> !output_hold_mode_bit && !pin26_function_bit)
        else $error("mode bits not cleared by reset");
    reset_cal_a: assert property (@(posedge sys_clk)
        $fell(rst) |=> calibrating && !busy_n)
        else $error("no calibration after reset");

    // a rising edge on the reused pin holds the sample and converts
    sequence trig_launch_s;
        state == AHP_IDLE && trig_rise && !cal_req;
    endsequence
    sequence conv_enter_s;
        state == AHP_CONV && count == 8'h00 && !sample_hold;
    endsequence
    trig_conv_a: assert property (@(posedge sys_clk) disable iff (rst)
        trig_launch_s |=> conv_enter_s)
        else $error("hold trigger did not convert");
    hold_start_a: assert property (@(posedge sys_clk) disable iff (rst)
        conv_enter_s |-> ##5 sample_hold && !$past(sample_hold))
        else $error("hold not entered after settling");
    pin_reuse_a: assert property (@(posedge sys_clk) disable iff (rst)
        state == AHP_IDLE && pin26_function_bit && !trim_request_n && !cal_cmd &&
        !cal_at_reset && !aux_cal |=> !calibrating)
        else $error("reused pin still calibrates");

    // transparent mode passes every decision straight through
    trans_bit_a: assert property (@(posedge sys_clk) disable iff (rst)
        $past(in_sar) && !$past(output_hold_mode_bit) |->
        out_reg[$past(bit_idx)] == $past(cmp_decision))
        else $error("decision not passed through");
    msb_ready_a: assert property (@(posedge sys_clk) disable iff (rst)
        state == AHP_CONV && count == MSB_READY_CYCLE && !output_hold_mode_bit &&
        !$past(output_hold_mode_bit, 4) |->
        out_reg[11:8] == {$past(cmp_decision, 4), $past(cmp_decision, 3),
                          $past(cmp_decision, 2), $past(cmp_decision, 1)})
        else $error("top bits not ready");

    // latched mode loads the finished word in one step
    latch_load_a: assert property (@(posedge sys_clk) disable iff (rst)
        output_hold_mode_bit && conv_done |=>
        out_reg[11:1] == $past(sar[11:1]) && out_reg[0] == $past(cmp_decision))
        else $error("latched result not loaded");
    full_result_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(busy_n) |-> out_reg == sar)
        else $error("result incomplete at busy high");
    busy_cal_a: assert property (@(posedge sys_clk) disable iff (rst)
        calibrating || sample_hold |-> !busy_n)
        else $error("busy high while working");

    // read side: byte contents, drive and live byte switching
    high_byte_a: assert property (@(posedge sys_clk) disable iff (rst)
        rd_int && host.upper_byte_sel && !host.aux_reg_select |->
        bus.dout[3:0] == out_reg[11:8])
        else $error("high byte result bits wrong");
    aux_read_a: assert property (@(posedge sys_clk) disable iff (rst)
        rd_int && host.upper_byte_sel && host.aux_reg_select |->
        bus.dout[0] == output_hold_mode_bit && bus.dout[2] == pin26_function_bit &&
        bus.dout[STATUS_BIT] == !busy_n)
        else $error("aux byte wrong");
    read_drive_a: assert property (@(posedge sys_clk) disable iff (rst)
        !host.cs_n && !host.rd_n |-> bus.doe == 8'hff)
        else $error("bus not driven in read");
    byte_follow_a: assert property (@(posedge sys_clk) disable iff (rst)
        rd_int && $past(rd_int) && $changed(host.upper_byte_sel) &&
        !host.aux_reg_select |->
        bus.dout[3:0] == (host.upper_byte_sel ? out_reg[11:8] : out_reg[3:0]))
        else $error("byte select not followed");
endmodule : ahp_port

// ---- testbench/adc_host_port_readout_test.sv ----
// Purpose: self-checking bench of the converter host port
// Assumes: comparator held constant per conversion, so results are 000 or fff
// Notes: busy interval lengths are measured by a run counter
`timescale 1ns/1ps
module adc_host_port_readout_test;
    import ahp_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic trim_request_n = 1'b1;
    logic cmp_decision = 1'b0;
    ahp_host_t host;
    logic [BUS_W-1:0] bus_in;
    ahp_bus_out_t bus;
    logic busy_n, sample_hold, calibrating;
    logic [1:0] analog_channel;
    logic [7:0] lo, hi, oe;
    int err_total = 0;
    int n_checks = 0;
    int low_run = 0;
    int last_run = 0;
    int exp_res = 0;
    int exp_q[$];
    int b;

    always #2 sys_clk = ~sys_clk;

    ahp_port u_ahp_port(.sys_clk(sys_clk), .rst(rst), .host(host),
        .trim_request_n(trim_request_n), .bus_in(bus_in), .cmp_decision(cmp_decision),
        .bus(bus), .busy_n(busy_n), .analog_channel(analog_channel),
        .sample_hold(sample_hold), .calibrating(calibrating));
    ahp_host_model u_ahp_host_model(.sys_clk(sys_clk), .bus(bus), .host(host),
        .bus_in(bus_in));

    // length of the last busy interval
    always @(posedge sys_clk) begin
        if (busy_n === 1'b0) low_run <= low_run + 1;
        else if (low_run != 0) begin
            last_run <= low_run;
            low_run <= 0;
        end
    end

    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // wait for busy high, then check the interval length
    task automatic wait_idle(input int len);
        for (int i = 0; i < 400 && busy_n !== 1'b0; i++) @(negedge sys_clk);
        for (int i = 0; i < 400 && busy_n !== 1'b1; i++) @(negedge sys_clk);
        @(negedge sys_clk);
        check("busy len", last_run[11:0], len[11:0]);
    endtask : wait_idle

    // read both bytes and compare with the model result
    task automatic read_cmp(input logic hb, input int r, input logic st);
        u_ahp_host_model.read_op(hb, 1'b0, lo, hi, oe);
        check("low", {4'h0, lo}, r[11:0] & 12'h0ff);
        check("high", {4'h0, hi}, {4'h0, st, 3'h0, r[11:8]});
        check("oe", {4'h0, oe}, 12'h0ff);
        @(negedge sys_clk);
        check("oe idle", {4'h0, bus.doe}, 12'h000);
    endtask : read_cmp

    task automatic trim_pulse();
        @(posedge sys_clk);
        trim_request_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        trim_request_n <= 1'b1;
    endtask : trim_pulse

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'hc4d6));
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        wait_idle(CAL_CYCLES + CONV_CYCLES);
        // conversions on every channel, transparent mode
        for (int ch = 0; ch < 4; ch++) begin
            b = $urandom_range(1, 0);
            @(posedge sys_clk);
            cmp_decision <= b[0];
            exp_q.push_back(b ? 12'hfff : 12'h000);
            u_ahp_host_model.write_op(ch[1:0], 1'b0, 8'h00);
            @(negedge sys_clk);
            check("busy start", busy_n, 1'b0);
            check("sampling", sample_hold, 1'b0);
            check("channel", analog_channel, ch[1:0]);
            repeat (PRE_CYCLES) @(negedge sys_clk);
            check("holding", sample_hold, 1'b1);
            wait_idle(CONV_CYCLES);
            read_cmp(ch[0], exp_q.pop_front(), 1'b0);
        end
        // latched mode plus hold trigger function of the request pin
        @(posedge sys_clk);
        cmp_decision <= 1'b1;
        u_ahp_host_model.write_op(2'h1, 1'b1, 8'h05);
        wait_idle(CONV_CYCLES);
        u_ahp_host_model.read_op(1'b1, 1'b1, lo, hi, oe);
        check("aux", {4'h0, hi}, 12'h005);
        exp_res = 12'hfff;
        cmp_decision <= 1'b0;
        trim_pulse();
        repeat (3) @(posedge sys_clk);
        read_cmp(1'b0, exp_res, 1'b1);
        wait_idle(CONV_CYCLES);
        read_cmp(1'b1, 12'h000, 1'b0);
        // back to calibration function, then a requested calibration
        u_ahp_host_model.write_op(2'h0, 1'b1, 8'h00);
        wait_idle(CONV_CYCLES);
        trim_pulse();
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        check("calibrating", calibrating, 1'b1);
        wait_idle(CAL_CYCLES + CONV_CYCLES);
        tally_and_finish();
    end
endmodule : adc_host_port_readout_test

// ---- testbench/ahp_host_model.sv ----
// Purpose: host processor model driving strobes, address and data lines
// Assumes: strobes change just after a rising edge of sys_clk
// Notes: released data lines show the inverse of their last value
`timescale 1ns/1ps
module ahp_host_model
    import ahp_pkg::*;
(
    input wire logic sys_clk,
    input wire ahp_bus_out_t bus,
    output ahp_host_t host,
    output logic [BUS_W-1:0] bus_in
);
    initial begin
        host = 7'h70;
        bus_in = 8'h00;
    end

    // one write pulse, aux register access when aux is set
    task automatic write_op(input logic [1:0] ch, input logic aux, input logic [7:0] d);
        @(posedge sys_clk);
        host <= {3'b010, aux, aux, ch};
        bus_in <= d;
        @(posedge sys_clk);
        host.cs_n <= 1'b1;
        host.wr_n <= 1'b1;
        @(posedge sys_clk);
        bus_in <= ~d;
    endtask : write_op

    // one read access taking both bytes, byte select switched mid-access
    task automatic read_op(input logic hb, input logic aux, output logic [7:0] lo,
                           output logic [7:0] hi, output logic [7:0] oe);
        @(posedge sys_clk);
        host <= {3'b001, hb, aux, host.chan_sel_1, host.chan_sel_0};
        @(posedge sys_clk);
        if (hb) hi = bus.dout;
        else lo = bus.dout;
        oe = bus.doe;
        host.upper_byte_sel <= ~hb;
        @(posedge sys_clk);
        if (hb) lo = bus.dout;
        else hi = bus.dout;
        host.cs_n <= 1'b1;
        host.rd_n <= 1'b1;
    endtask : read_op
endmodule : ahp_host_model
